// *** rtl/rtc_alarm_defs.vh ***
// Register offsets, field positions and reset values of the clock register side
`ifndef RTC_ALARM_DEFS_VH
`define RTC_ALARM_DEFS_VH

// SFR offsets
`define OFS_CLOCK_CONFIG 8'hA1
`define OFS_ALARM_EN 8'hA2
`define OFS_IND_PTR 8'hA3
`define OFS_IND_DATA 8'hA4
`define OFS_WRITE_KEY 8'hC1
`define OFS_NOM_TRIM 8'hF6
`define OFS_TEMP_TRIM 8'hF7

// Field positions
`define ALARM_FLAG_BIT 6
`define ALARM_EN_MSB 4
`define PTR_WRITE_BIT 7
`define PTR_ADDR_MSB 4

// Key that unlocks one indirect write
`define WRITE_KEY_VALUE 8'hEA

// Indirect addresses
`define IND_ALARM_FIRST 5'h0A
`define IND_ALARM_LAST 5'h0E
`define IND_COUNTER_FIRST 5'h02

// Reset values
`define RST_BYTE 8'h00
`define RST_ADDR 5'h00
`define RST_EN 5'h00

// Key sequence stages
`define KEY_IDLE 2'h0
`define KEY_LOADED 2'h1
`define KEY_DATA 2'h2

`endif

// *** rtl/alarm_field_match.v ***
// Per-field alarm comparison with enables
`timescale 1ns/1ps

module alarm_field_match #(
    parameter FIELDS = 5,
    parameter WIDTH = 8
) (
    input wire [FIELDS-1:0] fieldEnable,
    input wire [FIELDS*WIDTH-1:0] alarmVec,
    input wire [FIELDS*WIDTH-1:0] counterVec,
    output wire allMatch
);

    wire [FIELDS-1:0] fieldHit;

    genvar i;
    generate
        for (i = 0; i < FIELDS; i = i + 1) begin : gField
            // A disabled field never blocks the match
            assign fieldHit[i] = ~fieldEnable[i] |
                (alarmVec[i*WIDTH +: WIDTH] == counterVec[i*WIDTH +: WIDTH]);
        end
    endgenerate

    // At least one field must be enabled
    assign allMatch = (&fieldHit) & (|fieldEnable);

endmodule // alarm_field_match

// *** rtl/crystal_trim_reg.v ***
// One 8-bit crystal compensation register
`timescale 1ns/1ps
`include "rtc_alarm_defs.vh"

module crystal_trim_reg #(
    parameter WIDTH = 8
) (
    input wire mclk,
    input wire rst_n,
    input wire clearReq,
    input wire wrEn,
    input wire [WIDTH-1:0] wrData,
    output reg [WIDTH-1:0] value_reg
);

    always @(posedge mclk) begin
        if (!rst_n || clearReq) begin
            value_reg <= `RST_BYTE;
        end else if (wrEn) begin
            value_reg <= wrData;
        end
    end

endmodule // crystal_trim_reg

// *** rtl/rtc_alarm_access.v ***
// Alarm enables, alarm match, indirect pointer access, write key and trim registers
`timescale 1ns/1ps
`include "rtc_alarm_defs.vh"

module rtc_alarm_access #(
    parameter FIELDS = 5,
    parameter WIDTH = 8
) (
    input wire mclk,
    input wire rst_n,
    input wire [7:0] sfrAddr,
    input wire [7:0] sfrWrData,
    input wire sfrWr,
    input wire sfrRd,
    output reg [7:0] sfrRdData_reg,
    input wire clockIntEnable,
    output wire rtcIrq,
    output reg alarmFlag_reg,
    input wire counterUpdate,
    input wire [WIDTH-1:0] secondCount,
    input wire [WIDTH-1:0] minuteCount,
    input wire [WIDTH-1:0] hourCount,
    input wire [WIDTH-1:0] weekdayCount,
    input wire [WIDTH-1:0] dateCount,
    output wire [4:0] timekeepAddr,
    output wire timekeepWrEn,
    output wire [WIDTH-1:0] timekeepWrData,
    input wire [WIDTH-1:0] timekeepRdData,
    input wire watchdogReset,
    input wire externalReset,
    input wire powerOnReset,
    output wire [WIDTH-1:0] nominalTrim,
    output wire [WIDTH-1:0] temperatureTrim
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------

    reg [FIELDS-1:0] fieldEnable_reg;
    reg ptrWrite_reg;
    reg [4:0] ptrAddr_reg;
    reg [WIDTH-1:0] dataWindow_reg;
    reg [WIDTH-1:0] writeKey_reg;
    reg [1:0] keyStage_reg;
    reg [1:0] keyStage_next;
    reg readPend_reg;
    reg writePend_reg;

    wire wrConfig;
    wire wrEnable;
    wire wrPointer;
    wire wrData;
    wire wrKey;
    wire wrNomTrim;
    wire wrTempTrim;
    wire keyValid;
    wire targetIsAlarm;
    wire [4:0] alarmIndex;
    wire [FIELDS*WIDTH-1:0] alarmVec;
    wire [FIELDS*WIDTH-1:0] counterVec;
    wire allMatch;
    wire alarmSet;
    wire alarmClear;
    reg [WIDTH-1:0] indirectRead;
    wire trimClear;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------

    // Strobes are one-cycle pulses, so every decode is one too
    assign wrConfig = sfrWr && (sfrAddr == `OFS_CLOCK_CONFIG);
    assign wrEnable = sfrWr && (sfrAddr == `OFS_ALARM_EN);
    assign wrPointer = sfrWr && (sfrAddr == `OFS_IND_PTR);
    assign wrData = sfrWr && (sfrAddr == `OFS_IND_DATA);
    assign wrKey = sfrWr && (sfrAddr == `OFS_WRITE_KEY);
    assign wrNomTrim = sfrWr && (sfrAddr == `OFS_NOM_TRIM);
    assign wrTempTrim = sfrWr && (sfrAddr == `OFS_TEMP_TRIM);

    // ------------------------------------------------------------
    // Alarm field enables
    // ------------------------------------------------------------

    always @(posedge mclk) begin
        if (!rst_n) begin
            fieldEnable_reg <= `RST_EN;
        end else if (wrEnable) begin
            fieldEnable_reg <= sfrWrData[`ALARM_EN_MSB:0];
        end
    end

    // ------------------------------------------------------------
    // Write key sequencing
    // ------------------------------------------------------------

    // Key must be loaded, then data written, then pointer written
    always @* begin
        keyStage_next = `KEY_IDLE;
        if (wrKey) begin
            keyStage_next = `KEY_LOADED;
        end else if (wrData) begin
            if (keyStage_reg == `KEY_LOADED) begin
                keyStage_next = `KEY_DATA;
            end else begin
                keyStage_next = `KEY_IDLE;
            end
        end else if (sfrWr) begin
            keyStage_next = `KEY_IDLE;
        end else begin
            keyStage_next = keyStage_reg;
        end
    end

    assign keyValid = (writeKey_reg == `WRITE_KEY_VALUE) &&
        (keyStage_reg == `KEY_DATA);

    always @(posedge mclk) begin
        if (!rst_n) begin
            keyStage_reg <= `KEY_IDLE;
        end else begin
            keyStage_reg <= keyStage_next;
        end
    end

    // A failed attempt keeps the key but has to restart the sequence
    always @(posedge mclk) begin
        if (!rst_n) begin
            writeKey_reg <= `RST_BYTE;
        end else if (wrKey) begin
            writeKey_reg <= sfrWrData;
        end else if (wrPointer && sfrWrData[`PTR_WRITE_BIT] && keyValid) begin
            writeKey_reg <= `RST_BYTE;
        end
    end

    // ------------------------------------------------------------
    // Indirect pointer
    // ------------------------------------------------------------

    always @(posedge mclk) begin
        if (!rst_n) begin
            ptrWrite_reg <= 1'b0;
            ptrAddr_reg <= `RST_ADDR;
        end else if (wrPointer) begin
            ptrWrite_reg <= sfrWrData[`PTR_WRITE_BIT];
            ptrAddr_reg <= sfrWrData[`PTR_ADDR_MSB:0];
        end
    end

    // Transfer runs in the cycle after the pointer write
    always @(posedge mclk) begin
        if (!rst_n) begin
            readPend_reg <= 1'b0;
            writePend_reg <= 1'b0;
        end else begin
            readPend_reg <= wrPointer && !sfrWrData[`PTR_WRITE_BIT];
            writePend_reg <= wrPointer && sfrWrData[`PTR_WRITE_BIT] &&
                keyValid;
        end
    end

    assign alarmIndex = ptrAddr_reg - `IND_ALARM_FIRST;
    assign targetIsAlarm = (ptrAddr_reg >= `IND_ALARM_FIRST) &&
        (ptrAddr_reg <= `IND_ALARM_LAST);

    // ------------------------------------------------------------
    // Timekeeping side port
    // ------------------------------------------------------------

    assign timekeepAddr = ptrAddr_reg;
    // Alarm address writes are served here and never strobe the counter side, though the address still appears on timekeepAddr
    assign timekeepWrEn = writePend_reg && !targetIsAlarm;
    assign timekeepWrData = dataWindow_reg;

    // ------------------------------------------------------------
    // Indirect read source
    // ------------------------------------------------------------

    // Alarm bytes answer from this block, other addresses from the counters
    always @* begin
        indirectRead = timekeepRdData;
        if (targetIsAlarm) begin
            indirectRead = alarmVec[alarmIndex*WIDTH +: WIDTH];
        end
    end

    // ------------------------------------------------------------
    // Data window
    // ------------------------------------------------------------

    always @(posedge mclk) begin
        if (!rst_n) begin
            dataWindow_reg <= `RST_BYTE;
        end else if (wrData) begin
            dataWindow_reg <= sfrWrData;
        end else if (readPend_reg) begin
            dataWindow_reg <= indirectRead;
        end
    end

    // ------------------------------------------------------------
    // Alarm registers
    // ------------------------------------------------------------

    genvar g;
    generate
        for (g = 0; g < FIELDS; g = g + 1) begin : gAlarm
            reg [WIDTH-1:0] alarmByte_reg;
            always @(posedge mclk) begin
                if (!rst_n) begin
                    alarmByte_reg <= `RST_BYTE;
                end else if (writePend_reg && targetIsAlarm && (alarmIndex == g)) begin
                    alarmByte_reg <= dataWindow_reg;
                end
            end
            assign alarmVec[g*WIDTH +: WIDTH] = alarmByte_reg;
        end
    endgenerate

    // Field order matches enable bits: second, minute, hour, weekday, date
    assign counterVec = {dateCount, weekdayCount, hourCount,
        minuteCount, secondCount};

    // ------------------------------------------------------------
    // Alarm match and flag
    // ------------------------------------------------------------

    alarm_field_match #(
        .FIELDS(FIELDS),
        .WIDTH(WIDTH)
    ) uMatch (
        .fieldEnable(fieldEnable_reg),
        .alarmVec(alarmVec),
        .counterVec(counterVec),
        .allMatch(allMatch)
    );

    assign alarmSet = counterUpdate && allMatch;
    assign alarmClear = wrConfig && !sfrWrData[`ALARM_FLAG_BIT];

    // A set in the clearing cycle wins
    always @(posedge mclk) begin
        if (!rst_n) begin
            alarmFlag_reg <= 1'b0;
        end else if (alarmSet) begin
            alarmFlag_reg <= 1'b1;
        end else if (alarmClear) begin
            alarmFlag_reg <= 1'b0;
        end
    end

    assign rtcIrq = alarmFlag_reg && clockIntEnable;

    // ------------------------------------------------------------
    // Compensation registers
    // ------------------------------------------------------------

    assign trimClear = watchdogReset || externalReset || powerOnReset;

    crystal_trim_reg #(
        .WIDTH(WIDTH)
    ) uNomTrim (
        .mclk(mclk),
        .rst_n(rst_n),
        .clearReq(trimClear),
        .wrEn(wrNomTrim),
        .wrData(sfrWrData),
        .value_reg(nominalTrim)
    );

    crystal_trim_reg #(
        .WIDTH(WIDTH)
    ) uTempTrim (
        .mclk(mclk),
        .rst_n(rst_n),
        .clearReq(trimClear),
        .wrEn(wrTempTrim),
        .wrData(sfrWrData),
        .value_reg(temperatureTrim)
    );

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------

    // Reserved bits read as zero
    always @(posedge mclk) begin
        if (!rst_n) begin
            sfrRdData_reg <= `RST_BYTE;
        end else if (sfrRd) begin
            case (sfrAddr)
                `OFS_CLOCK_CONFIG: begin
                    sfrRdData_reg <= {1'b0, alarmFlag_reg, 6'h00};
                end
                `OFS_ALARM_EN: begin
                    sfrRdData_reg <= {3'h0, fieldEnable_reg};
                end
                `OFS_IND_PTR: begin
                    sfrRdData_reg <= {ptrWrite_reg, 2'h0, ptrAddr_reg};
                end
                `OFS_IND_DATA: begin
                    sfrRdData_reg <= dataWindow_reg;
                end
                `OFS_WRITE_KEY: begin
                    sfrRdData_reg <= writeKey_reg;
                end
                `OFS_NOM_TRIM: begin
                    sfrRdData_reg <= nominalTrim;
                end
                `OFS_TEMP_TRIM: begin
                    sfrRdData_reg <= temperatureTrim;
                end
                default: begin
                    sfrRdData_reg <= `RST_BYTE;
                end
            endcase
        end
    end

endmodule // rtc_alarm_access

// *** bench/rtc_alarm_access_chk.sv ***
// Assertion checker for the clock register side
`timescale 1ns/1ps

module rtc_alarm_access_chk #(
    parameter FIELDS = 5,
    parameter WIDTH = 8
) (
    input wire mclk,
    input wire rst_n,
    input wire [7:0] sfrAddr,
    input wire [7:0] sfrWrData,
    input wire sfrWr,
    input wire clockIntEnable,
    input wire rtcIrq,
    input wire alarmFlag_reg,
    input wire counterUpdate,
    input wire [4:0] timekeepAddr,
    input wire timekeepWrEn,
    input wire [WIDTH-1:0] timekeepWrData,
    input wire watchdogReset,
    input wire externalReset,
    input wire powerOnReset,
    input wire [WIDTH-1:0] nominalTrim,
    input wire [WIDTH-1:0] temperatureTrim
);
    wire keyW = sfrWr && sfrAddr == 8'hC1 && sfrWrData == 8'hEA;
    wire datW = sfrWr && sfrAddr == 8'hA4;
    wire ptrW = sfrWr && sfrAddr == 8'hA3;
    wire ptrWW = ptrW && sfrWrData[7];
    wire clrW = sfrWr && sfrAddr == 8'hA1 && !sfrWrData[6];
    wire anyRst = watchdogReset || externalReset || powerOnReset;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_irq_follows_flag: assert property (
        rtcIrq == (alarmFlag_reg && clockIntEnable)) else $error("irq mismatch");
    a_flag_on_update: assert property (
        $rose(alarmFlag_reg) |-> $past(counterUpdate)) else $error("flag set without update");
    a_flag_holds: assert property (
        alarmFlag_reg && !clrW |=> alarmFlag_reg) else $error("flag dropped");
    a_flag_clears: assert property (
        clrW && !counterUpdate |=> !alarmFlag_reg) else $error("flag not cleared");
    a_write_keyed: assert property (
        timekeepWrEn |-> $past(ptrWW) && $past(datW, 2) && $past(keyW, 3))
        else $error("indirect write without key sequence");
    a_write_data: assert property (
        timekeepWrEn |-> timekeepWrData == $past(sfrWrData, 2)) else $error("bad write data");
    a_write_single: assert property (
        timekeepWrEn |=> !timekeepWrEn) else $error("write pulse too long");
    a_ptr_address: assert property (
        ptrW |=> {3'h0, timekeepAddr} == ($past(sfrWrData) & 8'h1F)) else $error("bad address");
    a_trim_cleared: assert property (
        anyRst |=> nominalTrim == 8'h00 && temperatureTrim == 8'h00) else $error("trim kept");
endmodule // rtc_alarm_access_chk

bind rtc_alarm_access rtc_alarm_access_chk #(.FIELDS(FIELDS), .WIDTH(WIDTH)) chk (
    .mclk(mclk), .rst_n(rst_n), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData), .sfrWr(sfrWr),
    .clockIntEnable(clockIntEnable), .rtcIrq(rtcIrq), .alarmFlag_reg(alarmFlag_reg),
    .counterUpdate(counterUpdate), .timekeepAddr(timekeepAddr), .timekeepWrEn(timekeepWrEn),
    .timekeepWrData(timekeepWrData), .watchdogReset(watchdogReset),
    .externalReset(externalReset), .powerOnReset(powerOnReset), .nominalTrim(nominalTrim),
    .temperatureTrim(temperatureTrim));

// *** bench/timekeep_counter_model.sv ***
// Timekeeping counter bank answering the indirect port
`timescale 1ns/1ps

module timekeep_counter_model (
    input wire mclk,
    input wire [4:0] addr,
    input wire wrEn,
    input wire [7:0] wrData,
    output wire [7:0] rdData,
    output wire [39:0] counts
);
    logic [7:0] mem [0:31];
    initial for (int i = 0; i < 32; i++) mem[i] = 8'h00;
    always @(posedge mclk) begin
        if (wrEn) begin
            mem[addr] <= wrData;
        end
    end
    assign rdData = mem[addr];
    assign counts = {mem[6], mem[5], mem[4], mem[3], mem[2]};
endmodule // timekeep_counter_model

// *** bench/testbench.sv ***
// Self-checking bench for the clock register side
`timescale 1ns/1ps

module testbench;
    logic mclk = 0, rst_n = 0, sfrWr = 0, sfrRd = 0, clockIntEnable = 0, counterUpdate = 0;
    logic watchdogReset = 0, externalReset = 0, powerOnReset = 0;
    logic [7:0] sfrAddr = 8'h00, sfrWrData = 8'h00;
    wire [7:0] sfrRdData_reg, timekeepWrData, timekeepRdData, nominalTrim, temperatureTrim;
    wire [4:0] timekeepAddr;
    wire [39:0] counts;
    wire rtcIrq, alarmFlag_reg, timekeepWrEn;
    int fail_count = 0, total_checks = 0;

    always #2 mclk = ~mclk;

    rtc_alarm_access dut (.mclk(mclk), .rst_n(rst_n), .sfrAddr(sfrAddr),
        .sfrWrData(sfrWrData), .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrRdData_reg(sfrRdData_reg),
        .clockIntEnable(clockIntEnable), .rtcIrq(rtcIrq), .alarmFlag_reg(alarmFlag_reg),
        .counterUpdate(counterUpdate), .secondCount(counts[7:0]), .minuteCount(counts[15:8]),
        .hourCount(counts[23:16]), .weekdayCount(counts[31:24]), .dateCount(counts[39:32]),
        .timekeepAddr(timekeepAddr), .timekeepWrEn(timekeepWrEn),
        .timekeepWrData(timekeepWrData), .timekeepRdData(timekeepRdData),
        .watchdogReset(watchdogReset), .externalReset(externalReset),
        .powerOnReset(powerOnReset), .nominalTrim(nominalTrim),
        .temperatureTrim(temperatureTrim));
    timekeep_counter_model partner (.mclk(mclk), .addr(timekeepAddr), .wrEn(timekeepWrEn),
        .wrData(timekeepWrData), .rdData(timekeepRdData), .counts(counts));

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        if (!mclk) @(posedge mclk);
        sfrAddr <= a;
        sfrWrData <= d;
        sfrWr <= 1'b1;
        @(posedge mclk);
    endtask
    task idle;
        if (!mclk) @(posedge mclk);
        sfrWr <= 1'b0;
        @(posedge mclk);
        @(negedge mclk);
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        if (!mclk) @(posedge mclk);
        sfrWr <= 1'b0;
        sfrAddr <= a;
        sfrRd <= 1'b1;
        @(posedge mclk);
        sfrRd <= 1'b0;
        @(negedge mclk);
        chk(sfrRdData_reg, exp);
    endtask
    task kw(input logic [4:0] a, input logic [7:0] d);
        wr(8'hC1, 8'hEA);
        wr(8'hA4, d);
        wr(8'hA3, {3'b100, a});
        idle;
        idle;
    endtask
    task pulse;
        if (!mclk) @(posedge mclk);
        sfrWr <= 1'b0;
        counterUpdate <= 1'b1;
        @(posedge mclk);
        counterUpdate <= 1'b0;
        @(posedge mclk);
        @(negedge mclk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset_values;
        rd(8'hA2, 8'h00);
        rd(8'hA3, 8'h00);
        rd(8'hA4, 8'h00);
        rd(8'hF6, 8'h00);
        rd(8'hF7, 8'h00);
        rd(8'h55, 8'h00);
    endtask
    task t_plain_regs;
        wr(8'hA2, 8'hFF);
        wr(8'hF6, 8'hA5);
        wr(8'hF7, 8'h5A);
        rd(8'hA2, 8'h1F);
        rd(8'hF6, 8'hA5);
        rd(8'hF7, 8'h5A);
        chk(nominalTrim, 8'hA5);
        chk(temperatureTrim, 8'h5A);
        wr(8'hA3, 8'h65);
        idle;
        chk({3'h0, timekeepAddr}, 8'h05);
    endtask
    task t_indirect;
        kw(5'h02, 8'h37);
        chk(counts[7:0], 8'h37);
        rd(8'hC1, 8'h00);
        wr(8'hA4, 8'h11);
        wr(8'hA3, 8'h82);
        idle;
        idle;
        chk(counts[7:0], 8'h37);
        wr(8'hC1, 8'hEA);
        wr(8'hF6, 8'h00);
        wr(8'hA4, 8'h11);
        wr(8'hA3, 8'h82);
        idle;
        idle;
        chk(counts[7:0], 8'h37);
        wr(8'hA3, 8'h02);
        idle;
        rd(8'hA4, 8'h37);
        kw(5'h0C, 8'h17);
        wr(8'hA3, 8'h0C);
        idle;
        rd(8'hA4, 8'h17);
    endtask
    task t_alarm;
        @(posedge mclk);
        clockIntEnable <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            kw(5'(10 + i), 8'(16 + i));
            kw(5'(2 + i), 8'h20);
        end
        for (int i = 0; i < 5; i++) begin
            wr(8'hA2, 8'(1 << i));
            kw(5'(2 + i), 8'(16 + i));
            chk({7'h0, alarmFlag_reg}, 8'h00);
            pulse;
            chk({7'h0, alarmFlag_reg}, 8'h01);
            chk({7'h0, rtcIrq}, 8'h01);
            wr(8'hA1, 8'h40);
            idle;
            chk({7'h0, alarmFlag_reg}, 8'h01);
            wr(8'hA1, 8'h00);
            idle;
            chk({7'h0, alarmFlag_reg}, 8'h00);
            kw(5'(2 + i), 8'h20);
            pulse;
            chk({7'h0, alarmFlag_reg}, 8'h00);
        end
        for (int i = 0; i < 4; i++) kw(5'(2 + i), 8'(16 + i));
        wr(8'hA2, 8'h1F);
        clockIntEnable <= 1'b0;
        pulse;
        chk({7'h0, alarmFlag_reg}, 8'h00);
        kw(5'h06, 8'h14);
        pulse;
        chk({7'h0, alarmFlag_reg}, 8'h01);
        chk({7'h0, rtcIrq}, 8'h00);
        rd(8'hA1, 8'h40);
    endtask
    task t_trim_clear;
        for (int k = 0; k < 3; k++) begin
            wr(8'hF6, 8'h3C);
            wr(8'hF7, 8'hC3);
            idle;
            @(posedge mclk);
            {watchdogReset, externalReset, powerOnReset} <= 3'b100 >> k;
            @(posedge mclk);
            {watchdogReset, externalReset, powerOnReset} <= 3'b000;
            rd(8'hF6, 8'h00);
            rd(8'hF7, 8'h00);
            chk(nominalTrim, 8'h00);
            chk(temperatureTrim, 8'h00);
        end
    endtask

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task give_verdict;
        if (fail_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        fail_count++;
        give_verdict;
    end
    initial begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_reset_values;
        t_plain_regs;
        t_indirect;
        t_alarm;
        t_trim_clear;
        give_verdict;
    end
endmodule // testbench
